// >>> pmcs_top.sv
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "pmcs_defines.svh"
module pmcs_top
   import pmcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`PMCS_ADDR_W-1:0] reg_addr,
   input wire logic [`PMCS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`PMCS_DATA_W-1:0] reg_rdata,
   input wire logic sleep_exec,
   input wire logic wake_irq,
   input wire logic wdt_timeout,
   input wire logic primary_ready_pin,
   input wire logic secondary_ready_pin,
   input wire logic fast_int_ready_pin,
   input wire logic two_speed_pin,
   input wire logic failsafe_pin,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic [1:0] clk_src_sel,
   output logic primary_osc_en,
   output logic secondary_osc_run,
   output logic fast_osc_en,
   output logic slow_rc_en,
   output logic [2:0] fast_freq_sel
);
   logic [4:0] sync_q;
   logic pri_rdy, sec_rdy, fast_rdy, two_speed, failsafe;
   logic [`PMCS_DATA_W-1:0] ctrl_r, rdata_r;
   pmcs_state_type state_r;
   pmcs_src_type cur_r, tgt_r, target;
   logic [`PMCS_SW_W-1:0] sw_cnt_r;
   logic idle_r, waking_r;
   logic [`PMCS_CNT_W-1:0] tcsd_cnt_r, iof_cnt_r;
   logic iof_raw_r;
   logic cpu_clk_en_r, periph_clk_en_r, primary_osc_en_r;
   logic secondary_osc_run_r, fast_osc_en_r, slow_rc_en_r;
   logic [1:0] clk_src_sel_r;
   logic [2:0] fast_freq_sel_r;
   logic [1:0] sel;
   logic idle_en, int_src, t1en, wdt_en, fast_req, alt_start;
   logic sec_blocked, sleep_ok, wake_evt, asleep_ok, periph_on;
   logic tgt_ready, pri_flag, int_flag, sec_flag;
   pmcs_mode_type mode;

   pmcs_sync #(.W(5)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .d({failsafe_pin, two_speed_pin, fast_int_ready_pin,
          secondary_ready_pin, primary_ready_pin}),
      .q(sync_q)
   );

   assign pri_rdy = sync_q[0];
   assign sec_rdy = sync_q[1];
   assign fast_rdy = sync_q[2];
   assign two_speed = sync_q[3];
   assign failsafe = sync_q[4];

   assign sel = ctrl_r[`PMCS_SEL_MSB:`PMCS_SEL_LSB];
   assign idle_en = ctrl_r[`PMCS_IDLE_BIT];
   assign int_src = ctrl_r[`PMCS_INTERNAL_SOURCE_SELECT_BIT];
   assign t1en = ctrl_r[`PMCS_T1EN_BIT];
   assign wdt_en = ctrl_r[`PMCS_WDTEN_BIT];
   assign fast_req =
      (ctrl_r[`PMCS_FREQ_MSB:`PMCS_FREQ_LSB] != 3'h0) || int_src;
   assign alt_start = two_speed || failsafe;
   assign wake_evt = wake_irq || wdt_timeout;

   // Source decode; lower bit ignored when upper set
   always_comb begin
      if (sel[1])
         target = SRC_INT;
      else if (sel[0])
         target = SRC_SEC;
      else
         target = SRC_PRI;
   end

   assign sec_blocked = (target == SRC_SEC) && !t1en;
   // Idle enable sampled at the sleep instruction
   assign sleep_ok = sleep_exec && cpu_clk_en_r &&
      !(idle_en && sec_blocked);
   assign asleep_ok = sleep_ok &&
      ((state_r == ST_RUN) || (state_r == ST_SW_WAIT));

   always_comb begin
      case (tgt_r)
         SRC_PRI: tgt_ready = pri_rdy;
         SRC_SEC: tgt_ready = sec_rdy;
         SRC_INT: tgt_ready = 1'b1;
         default: tgt_ready = 1'b0;
      endcase
   end

   // Software owns the control word
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         ctrl_r <= `PMCS_CTRL_RST;
      else if (reg_wr && reg_addr == `PMCS_CTRL_ADDR)
         ctrl_r <= reg_wdata & `PMCS_CTRL_MASK;
   end

   // Clock source sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_WAKE;
         cur_r <= SRC_NONE;
         tgt_r <= SRC_PRI;
         sw_cnt_r <= '0;
      end else if (asleep_ok && !idle_en) begin
         state_r <= ST_SLEEP;
         cur_r <= SRC_NONE;
      end else begin
         case (state_r)
            ST_RUN: begin
               if (target != cur_r && !sec_blocked) begin
                  tgt_r <= target;
                  state_r <= ST_SW_WAIT;
               end
            end
            ST_SW_WAIT: begin
               if (target != tgt_r) begin
                  if (target == cur_r || sec_blocked)
                     state_r <= ST_RUN;
                  else
                     tgt_r <= target;
               end else if (tgt_ready) begin
                  state_r <= ST_SW_OLD;
                  sw_cnt_r <= '0;
               end
            end
            ST_SW_OLD: begin
               if (sw_cnt_r == `PMCS_OLD_CYC - 3'h1) begin
                  state_r <= ST_SW_NEW;
                  sw_cnt_r <= '0;
               end else begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
               end
            end
            ST_SW_NEW: begin
               if (sw_cnt_r == `PMCS_NEW_CYC - 3'h1) begin
                  cur_r <= tgt_r;
                  state_r <= ST_RUN;
               end else begin
                  sw_cnt_r <= sw_cnt_r + 3'h1;
               end
            end
            ST_SLEEP: begin
               if (wake_evt)
                  state_r <= ST_WAKE;
            end
            ST_WAKE: begin
               if (pri_rdy) begin
                  cur_r <= SRC_PRI;
                  state_r <= ST_RUN;
               end else if (alt_start) begin
                  cur_r <= SRC_INT;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // CPU gating: idle entry and the wake delay
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         idle_r <= 1'b0;
         waking_r <= 1'b1;
         tcsd_cnt_r <= '0;
      end else if (asleep_ok) begin
         idle_r <= idle_en;
         waking_r <= 1'b0;
         tcsd_cnt_r <= '0;
      end else if ((idle_r || state_r == ST_SLEEP) && wake_evt &&
                   !waking_r) begin
         waking_r <= 1'b1;
         tcsd_cnt_r <= '0;
      end else if (waking_r) begin
         if (tcsd_cnt_r == `PMCS_CNT_W'(`PMCS_TCSD_CYC)) begin
            waking_r <= 1'b0;
            idle_r <= 1'b0;
         end else begin
            tcsd_cnt_r <= tcsd_cnt_r + `PMCS_CNT_W'(1);
         end
      end
   end

   // Fast internal oscillator stabilization
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         iof_cnt_r <= '0;
         iof_raw_r <= 1'b0;
      end else if (!fast_osc_en_r) begin
         iof_cnt_r <= '0;
         iof_raw_r <= 1'b0;
      end else if (iof_cnt_r == `PMCS_CNT_W'(`PMCS_TIOBST_CYC)) begin
         iof_raw_r <= fast_rdy;
      end else begin
         iof_cnt_r <= iof_cnt_r + `PMCS_CNT_W'(1);
      end
   end

   // Clocks withheld in the switch gap and while Timer1 starts
   always_comb begin
      case (state_r)
         ST_RUN: periph_on = 1'b1;
         ST_SW_WAIT: periph_on = !(tgt_r == SRC_SEC && !sec_rdy);
         ST_WAKE: periph_on = (cur_r == SRC_INT);
         default: periph_on = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         periph_clk_en_r <= 1'b0;
         cpu_clk_en_r <= 1'b0;
         clk_src_sel_r <= SRC_PRI;
      end else begin
         periph_clk_en_r <= periph_on;
         cpu_clk_en_r <= periph_on && !idle_r && !waking_r;
         clk_src_sel_r <= cur_r;
      end
   end

   // Oscillator enables
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         primary_osc_en_r <= 1'b1;
         secondary_osc_run_r <= 1'b0;
         fast_osc_en_r <= 1'b0;
         slow_rc_en_r <= 1'b0;
         fast_freq_sel_r <= 3'h0;
      end else begin
         primary_osc_en_r <= (state_r == ST_WAKE) ||
            (state_r != ST_SLEEP && cur_r == SRC_PRI) ||
            (state_r != ST_RUN && state_r != ST_SLEEP &&
             tgt_r == SRC_PRI);
         secondary_osc_run_r <= t1en;
         fast_osc_en_r <= fast_req && state_r != ST_SLEEP;
         slow_rc_en_r <= wdt_en || failsafe ||
            (cur_r == SRC_INT && !fast_req);
         fast_freq_sel_r <=
            ctrl_r[`PMCS_FREQ_MSB:`PMCS_FREQ_LSB];
      end
   end

   // Status flags follow the source driving the clock; the internal flag also waits for iof_raw_r
   assign pri_flag = (cur_r == SRC_PRI);
   assign sec_flag = (cur_r == SRC_SEC);
   assign int_flag = (cur_r == SRC_INT) && iof_raw_r;

   always_comb begin
      if (state_r == ST_SLEEP)
         mode = sleep_mode;
      else if (waking_r && !idle_r)
         mode = waking_mode;
      else begin
         case (cur_r)
            SRC_PRI: mode = idle_r ? primary_idle_mode : primary_run_mode;
            SRC_SEC:
               mode = idle_r ? secondary_idle_mode : secondary_run_mode;
            SRC_INT:
               mode = idle_r ? internal_idle_mode : internal_run_mode;
            default: mode = waking_mode;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         rdata_r <= '0;
      else begin
         rdata_r <= '0;
         if (reg_rd) begin
            case (reg_addr)
               `PMCS_CTRL_ADDR: rdata_r <= ctrl_r;
               `PMCS_STAT_ADDR: begin
                  rdata_r[`PMCS_PRI_FLAG_BIT] <= pri_flag;
                  rdata_r[`PMCS_INT_FLAG_BIT] <= int_flag;
                  rdata_r[`PMCS_SEC_FLAG_BIT] <= sec_flag;
                  rdata_r[`PMCS_MODE_MSB:`PMCS_MODE_LSB] <= mode;
               end
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign cpu_clk_en = cpu_clk_en_r;
   assign periph_clk_en = periph_clk_en_r;
   assign clk_src_sel = clk_src_sel_r;
   assign primary_osc_en = primary_osc_en_r;
   assign secondary_osc_run = secondary_osc_run_r;
   assign fast_osc_en = fast_osc_en_r;
   assign slow_rc_en = slow_rc_en_r;
   assign fast_freq_sel = fast_freq_sel_r;

   a_sec_blocked:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_RUN && sec_blocked) |=> state_r != ST_SW_WAIT)
   else $error("Disabled Timer1 selection started a switch");

   a_sleep_stops:
   assert property (@(posedge clock) disable iff (!rst_n)
      (asleep_ok && !idle_en) |=> (cur_r == SRC_NONE && !pri_flag)
      ##1 (!periph_clk_en_r && !cpu_clk_en_r))
   else $error("Sleep did not stop clocks and flags");

   a_idle_gates_cpu:
   assert property (@(posedge clock) disable iff (!rst_n)
      (asleep_ok && idle_en && state_r == ST_RUN && target == cur_r &&
       !wake_evt) |=> idle_r ##1 (!cpu_clk_en_r && periph_clk_en_r))
   else $error("Idle entry did not gate only the CPU");

   a_switch_length:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_SW_WAIT ##1 state_r == ST_SW_OLD) |->
      (state_r == ST_SW_OLD)[*2] ##1 (state_r == ST_SW_NEW)[*3]
      ##1 state_r == ST_RUN)
   else $error("Switch did not take two plus three cycles");

   a_switch_gap:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_SW_OLD || state_r == ST_SW_NEW) |=>
      (!periph_clk_en_r && !cpu_clk_en_r))
   else $error("Clock enabled during switch gap");

   a_t1_start_wait:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_SW_WAIT && tgt_r == SRC_SEC && !sec_rdy) |=>
      !periph_clk_en_r)
   else $error("Peripherals clocked before Timer1 started");

   a_old_clock_kept:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_SW_WAIT && tgt_r == SRC_PRI) |=>
      (periph_clk_en_r && clk_src_sel_r == $past(cur_r)))
   else $error("Old clock not kept while primary starts");

   a_ctrl_hold:
   assert property (@(posedge clock) disable iff (!rst_n)
      !(reg_wr && reg_addr == `PMCS_CTRL_ADDR) |=> $stable(ctrl_r))
   else $error("Control word changed without a write");

   a_wake_delay:
   assert property (@(posedge clock) disable iff (!rst_n)
      $rose(waking_r) |=> (!cpu_clk_en_r)[*8])
   else $error("CPU clocked before wake delay");

   a_stable_delay:
   assert property (@(posedge clock) disable iff (!rst_n)
      $rose(iof_raw_r) |->
      (iof_cnt_r == `PMCS_CNT_W'(`PMCS_TIOBST_CYC) && fast_osc_en_r))
   else $error("Internal stable flag set early");

   a_wake_withheld:
   assert property (@(posedge clock) disable iff (!rst_n)
      (state_r == ST_WAKE && cur_r == SRC_NONE) |=> !periph_clk_en_r)
   else $error("Clocks given before primary ready");
endmodule // pmcs_top

// >>> pmcs_defines.svh
`ifndef PMCS_DEFINES_SVH
`define PMCS_DEFINES_SVH

// Register port geometry
`define PMCS_ADDR_W 8
`define PMCS_DATA_W 16
`define PMCS_CTRL_ADDR 8'h00
`define PMCS_STAT_ADDR 8'h04

// Control register fields
`define PMCS_SEL_MSB 1
`define PMCS_SEL_LSB 0
`define PMCS_IDLE_BIT 2
`define PMCS_FREQ_MSB 6
`define PMCS_FREQ_LSB 4
`define PMCS_INTERNAL_SOURCE_SELECT_BIT 7
`define PMCS_T1EN_BIT 8
`define PMCS_WDTEN_BIT 9
`define PMCS_CTRL_MASK 16'h03f7
`define PMCS_CTRL_RST 16'h0000

// Status register fields
`define PMCS_PRI_FLAG_BIT 0
`define PMCS_INT_FLAG_BIT 1
`define PMCS_SEC_FLAG_BIT 2
`define PMCS_MODE_MSB 6
`define PMCS_MODE_LSB 4

// Timing
`define PMCS_CLK_NS 10
`define PMCS_TIOBST_NS 1000
`define PMCS_TCSD_NS 2000
`define PMCS_CNT_W 8
`define PMCS_TIOBST_CYC \
   ((`PMCS_TIOBST_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS)
`define PMCS_TCSD_CYC \
   ((`PMCS_TCSD_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS)
`define PMCS_SW_W 3
`define PMCS_OLD_CYC 3'h2
`define PMCS_NEW_CYC 3'h3

`endif

// >>> pmcs_pkg.sv
package pmcs_pkg;

   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10,
      SRC_NONE = 2'b11
   } pmcs_src_type;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_SW_WAIT = 3'b001,
      ST_SW_OLD = 3'b010,
      ST_SW_NEW = 3'b011,
      ST_SLEEP = 3'b100,
      ST_WAKE = 3'b101
   } pmcs_state_type;

   typedef enum logic [2:0] {
      primary_run_mode = 3'b000,
      secondary_run_mode = 3'b001,
      internal_run_mode = 3'b010,
      primary_idle_mode = 3'b011,
      secondary_idle_mode = 3'b100,
      internal_idle_mode = 3'b101,
      sleep_mode = 3'b110,
      waking_mode = 3'b111
   } pmcs_mode_type;

endpackage

// >>> pmcs_sync.sv
`timescale 1ns/1ns
module pmcs_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               meta_r[i] <= 1'b0;
               hold_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= d[i];
               hold_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign q = hold_r;
endmodule // pmcs_sync

// >>> pmcs_osc_model.sv
`timescale 1ns/1ns
module pmcs_osc_model #(
   parameter int PRI_DLY = 40,
   parameter int SEC_DLY = 20,
   parameter int FAST_DLY = 30
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic primary_osc_en,
   input wire logic secondary_osc_run,
   input wire logic fast_osc_en,
   input wire logic pri_stall,
   output logic primary_ready_pin,
   output logic secondary_ready_pin,
   output logic fast_int_ready_pin
);
   int pri_cnt;
   int sec_cnt;
   int fast_cnt;

   // Start-up counts restart whenever an oscillator is stopped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pri_cnt <= 0;
         sec_cnt <= 0;
         fast_cnt <= 0;
      end else begin
         if (!primary_osc_en || pri_stall)
            pri_cnt <= 0;
         else if (pri_cnt < PRI_DLY)
            pri_cnt <= pri_cnt + 1;
         if (!secondary_osc_run)
            sec_cnt <= 0;
         else if (sec_cnt < SEC_DLY)
            sec_cnt <= sec_cnt + 1;
         if (!fast_osc_en)
            fast_cnt <= 0;
         else if (fast_cnt < FAST_DLY)
            fast_cnt <= fast_cnt + 1;
      end
   end

   // Ready only while running and past start-up
   assign primary_ready_pin = primary_osc_en && (pri_cnt >= PRI_DLY);
   assign secondary_ready_pin = secondary_osc_run && (sec_cnt >= SEC_DLY);
   assign fast_int_ready_pin = fast_osc_en && (fast_cnt >= FAST_DLY);
endmodule // pmcs_osc_model

// >>> pmcs_tb.sv
`timescale 1ns/1ns
`include "pmcs_defines.svh"
module tb
   import pmcs_pkg::*;
;
   logic clock, rst_n, reg_wr, reg_rd, sleep_exec, wake_irq, wdt_timeout;
   logic [`PMCS_ADDR_W-1:0] reg_addr;
   logic [`PMCS_DATA_W-1:0] reg_wdata, reg_rdata;
   logic pri_rdy, sec_rdy, fast_rdy, two_speed_pin, pri_stall, failsafe_pin;
   logic cpu_clk_en, periph_clk_en, primary_osc_en, secondary_osc_run;
   logic fast_osc_en, slow_rc_en;
   logic [1:0] clk_src_sel;
   logic [2:0] fast_freq_sel;
   int err_total, total_checks;
   localparam logic [7:0] CA = `PMCS_CTRL_ADDR;
   localparam logic [7:0] SA = `PMCS_STAT_ADDR;

   pmcs_top u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sleep_exec(sleep_exec), .wake_irq(wake_irq),
      .wdt_timeout(wdt_timeout), .primary_ready_pin(pri_rdy),
      .secondary_ready_pin(sec_rdy), .fast_int_ready_pin(fast_rdy),
      .two_speed_pin(two_speed_pin), .failsafe_pin(failsafe_pin),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .clk_src_sel(clk_src_sel), .primary_osc_en(primary_osc_en),
      .secondary_osc_run(secondary_osc_run), .fast_osc_en(fast_osc_en),
      .slow_rc_en(slow_rc_en), .fast_freq_sel(fast_freq_sel));

   pmcs_osc_model u_osc (.clock(clock), .rst_n(rst_n),
      .primary_osc_en(primary_osc_en), .secondary_osc_run(secondary_osc_run),
      .fast_osc_en(fast_osc_en), .pri_stall(pri_stall),
      .primary_ready_pin(pri_rdy), .secondary_ready_pin(sec_rdy),
      .fast_int_ready_pin(fast_rdy));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic close_out();
      $display("Checks %0d, errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic reg_is(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   // Poll status until masked value matches, bounded
   task automatic wait_stat(input logic [15:0] m, input logic [15:0] v);
      logic [15:0] d;
      int n;
      n = 0;
      do begin
         rd(SA, d);
         n++;
      end while ((d & m) !== v && n < 400);
      check(d & m, v);
      if ((d & m) !== v)
         close_out();
   endtask

   task automatic pulse(input int k);
      @(posedge clock);
      sleep_exec <= (k == 0);
      wake_irq <= (k == 1);
      wdt_timeout <= (k == 2);
      @(posedge clock);
      sleep_exec <= 1'b0;
      wake_irq <= 1'b0;
      wdt_timeout <= 1'b0;
   endtask

   task automatic t_reset();
      wait_stat(16'h0077, 16'h0001);
      reg_is(CA, `PMCS_CTRL_RST);
      wr(8'h08, 16'hffff);
      reg_is(8'h08, 16'h0000);
      wr(SA, 16'hffff);
      reg_is(SA, 16'h0001);
      wr(CA, 16'hfc08);
      reg_is(CA, 16'h0000);
      repeat (210) @(posedge clock);
   endtask

   task automatic t_secondary_run_mode();
      wr(CA, 16'h0001);
      repeat (20) @(posedge clock);
      check(16'(clk_src_sel), 16'h0000);
      reg_is(SA, 16'h0001);
      wr(CA, 16'h0101);
      repeat (6) @(posedge clock);
      check(16'({periph_clk_en, clk_src_sel}), 16'h0000);
      wait_stat(16'h0077, 16'h0014);
      repeat (2) @(posedge clock);
      check(16'({primary_osc_en, clk_src_sel}), 16'h0001);
      reg_is(CA, 16'h0101);
      wr(CA, 16'h0100);
      repeat (10) @(posedge clock);
      check(16'({periph_clk_en, clk_src_sel}), 16'h0005);
      wait_stat(16'h0077, 16'h0001);
      repeat (2) @(posedge clock);
      check(16'({secondary_osc_run, clk_src_sel}), 16'h0004);
   endtask

   task automatic t_internal();
      wr(CA, 16'h0002);
      wait_stat(16'h0077, 16'h0020);
      repeat (2) @(posedge clock);
      check(16'({primary_osc_en, fast_osc_en, slow_rc_en, clk_src_sel}),
         16'h0006);
      wr(CA, 16'h0052);
      repeat (2) @(posedge clock);
      check(16'(fast_freq_sel), 16'h0005);
      repeat (40) @(posedge clock);
      reg_is(SA, 16'h0020);
      check(16'(periph_clk_en), 16'h0001);
      wait_stat(16'h0077, 16'h0022);
      wr(CA, 16'h0053);
      repeat (10) @(posedge clock);
      reg_is(SA, 16'h0022);
      check(16'(clk_src_sel), 16'h0002);
   endtask

   task automatic t_int_idle();
      wr(CA, 16'h0056);
      pulse(0);
      repeat (3) @(posedge clock);
      check(16'({cpu_clk_en, periph_clk_en, clk_src_sel}), 16'h0006);
      reg_is(SA, 16'h0052);
      pulse(1);
      repeat (150) @(posedge clock);
      check(16'(cpu_clk_en), 16'h0000);
      wait_stat(16'h0077, 16'h0022);
      repeat (2) @(posedge clock);
      check(16'(cpu_clk_en), 16'h0001);
      reg_is(CA, 16'h0056);
   endtask

   task automatic t_sleep();
      wr(CA, 16'h0352);
      pulse(0);
      repeat (3) @(posedge clock);
      check(16'({cpu_clk_en, periph_clk_en, secondary_osc_run, slow_rc_en}),
         16'h0003);
      reg_is(SA, 16'h0060);
      pulse(2);
      repeat (10) @(posedge clock);
      check(16'(periph_clk_en), 16'h0000);
      wait_stat(16'h0070, 16'h0020);
      repeat (210) @(posedge clock);
      check(16'(cpu_clk_en), 16'h0001);
      reg_is(CA, 16'h0352);
   endtask

   task automatic t_idle_modes();
      wr(CA, 16'h0055);
      pulse(0);
      repeat (3) @(posedge clock);
      check(16'(cpu_clk_en), 16'h0001);
      reg_is(SA, 16'h0022);
      wr(CA, 16'h0004);
      wait_stat(16'h0077, 16'h0001);
      repeat (2) @(posedge clock);
      pulse(0);
      repeat (3) @(posedge clock);
      check(16'({cpu_clk_en, primary_osc_en, clk_src_sel}), 16'h0004);
      reg_is(SA, 16'h0031);
      pulse(1);
      wait_stat(16'h0077, 16'h0001);
      repeat (2) @(posedge clock);
      wr(CA, 16'h0104);
      wr(CA, 16'h0105);
      wait_stat(16'h0077, 16'h0014);
      repeat (2) @(posedge clock);
      pulse(0);
      repeat (3) @(posedge clock);
      reg_is(SA, 16'h0044);
      check(16'({primary_osc_en, periph_clk_en, clk_src_sel}), 16'h0005);
      pulse(2);
      wait_stat(16'h0077, 16'h0014);
   endtask

   task automatic t_two_speed();
      two_speed_pin <= 1'b1;
      pri_stall <= 1'b1;
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      check(16'({clk_src_sel, periph_clk_en}), 16'h0005);
      pri_stall <= 1'b0;
      wait_stat(16'h0071, 16'h0001);
      check(16'(slow_rc_en), 16'h0000);
      failsafe_pin <= 1'b1;
      repeat (5) @(posedge clock);
      check(16'(slow_rc_en), 16'h0001);
   endtask

   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      sleep_exec = 1'b0;
      wake_irq = 1'b0;
      wdt_timeout = 1'b0;
      two_speed_pin = 1'b0;
      failsafe_pin = 1'b0;
      pri_stall = 1'b0;
      err_total = 0;
      total_checks = 0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_secondary_run_mode();
      t_internal();
      t_int_idle();
      t_sleep();
      t_idle_modes();
      t_two_speed();
      close_out();
   end
endmodule // tb
